// file: rtl/cmw_pkg.sv
// package: register map, field layout and types of the compare-match waveform block
package cmw_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] CMW_OFF_TMR_CTRL  = 8'h00;
  localparam logic [7:0] CMW_OFF_ENABLE    = 8'h04;
  localparam logic [7:0] CMW_OFF_FUNC_SEL  = 8'h08;
  localparam logic [7:0] CMW_OFF_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] CMW_OFF_IRQ_MASK  = 8'h10;
  localparam logic [7:0] CMW_OFF_TIMER     = 8'h14;
  localparam logic [7:0] CMW_OFF_PRESCALE  = 8'h18;
  // per-channel pages: address bits [7:5] pick the page, [4:2] the channel
  localparam logic [2:0] CMW_PAGE_CH_CTRL  = 3'h2;
  localparam logic [2:0] CMW_PAGE_CH_CMP   = 3'h3;

  // base timer control fields
  localparam int CMW_CTRL_RUN   = 0;
  localparam int CMW_CTRL_CLR_A = 1;
  localparam int CMW_CTRL_CLR_B = 2;
  localparam int CMW_CTRL_W     = 3;

  // output mode field encodings
  localparam logic [2:0] CMW_MODE_SINGLE = 3'h0;
  localparam logic [2:0] CMW_MODE_PHASE  = 3'h1;
  localparam logic [2:0] CMW_MODE_SETRST = 3'h2;

  // widths and reset values
  localparam int          CMW_TIMER_W    = 16;
  localparam int          CMW_CHCTRL_W   = 6;
  localparam logic [15:0] CMW_TIMER_ZERO = 16'h0000;
  localparam logic [15:0] CMW_CMP_RST    = 16'h0000;
  localparam logic [15:0] CMW_PRESC_RST  = 16'h0000;
  localparam logic [2:0]  CMW_CTRL_RST   = 3'h0;
  localparam logic [1:0]  CMW_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  CMW_RESP_SLVERR = 2'h2;

  // one channel's output control register, bit 0 upward: mode, ivl, rld, inv
  typedef struct packed {
    logic       level_flip;
    logic       reload_timing_sel;
    logic       default_level_sel;
    logic [2:0] output_mode_field;
  } cmw_chan_ctrl_t;

  localparam cmw_chan_ctrl_t CMW_CHCTRL_RST = '0;

endpackage

// file: rtl/cmw_top.sv
// compare-match waveform generator: eight channels on a shared base timer, AXI4-Lite slave
// Contract
// - In single-phase mode a channel's output goes high when the timer equals its compare value.
// - In single-phase mode a high output returns low when the timer reaches zero.
// - The default level bit sets the output level at the moment generation starts.
// - The level flip bit inverts the generated waveform before it reaches the pin.
// - Free-running, a single-phase channel has period 65536, low width m, high width 65536-m.
// - With clear select A set and B clear, a channel-0 match clears the timer, period n+2.
// - In single-phase mode with channel-0 clearing, compare values of n+2 or more keep it low.
// - Software starts a channel by setting its enable bit and stops it by clearing it.
// - Every timer match with a channel's compare value sets that channel's match flag; here only enabled waveform channels set it.
// - In phase-delayed mode a channel's output toggles on each match.
// - Phase-delayed and free-running, high and low phases each last 65536 counts.
// - Phase-delayed with channel-0 clearing, phases last n+2, values of n+2 or more never toggle.
// - Each channel has a mode field choosing single-phase, phase-delayed or set/reset output; set/reset is not built and holds the default level.
// - Each channel has a reload select deciding when a written compare value becomes active.
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module cmw_top
  import cmw_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int ADDR_W = 8
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic [NUM_CH-1:0] waveform_out_pin,
  output var  logic              irq
);

  if (NUM_CH < 1 || NUM_CH > 8 || ADDR_W != 8)
  begin : g_bad_param
    $error("cmw_top: NUM_CH must be 1..8 and ADDR_W must be 8");
  end

  // registers
  logic [CMW_CTRL_W-1:0]  tmr_ctrl;
  logic [NUM_CH-1:0]      channel_enable_reg;
  logic [NUM_CH-1:0]      function_select_reg;
  logic [NUM_CH-1:0]      match_irq_flag;
  logic [NUM_CH-1:0]      irq_mask;
  logic [15:0]            prescale;
  cmw_chan_ctrl_t         channel_output_control [NUM_CH];
  logic [15:0]            channel_compare_value  [NUM_CH];
  logic [15:0]            cmp_active             [NUM_CH];

  // timer and tick
  logic [CMW_TIMER_W-1:0] base_timer;
  logic [15:0]            presc_cnt;
  logic                   timer_count_clock;
  logic                   clr_armed;
  logic                   tick;
  logic                   at_zero;
  logic                   clear_on_ch0;
  logic [NUM_CH-1:0]      match_hit;
  logic [NUM_CH-1:0]      active;

  // bus internals
  logic                   aw_held;
  logic                   w_held;
  logic [ADDR_W-1:0]      aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   wr_en;
  logic                   wr_ok;
  logic [31:0]            rd_mux;
  logic                   rd_ok;
  logic                   rd_stat;

  // merge byte lanes of a write into the old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  // a channel runs only when enabled and set for waveforms, not measurement
  assign active       = channel_enable_reg & ~function_select_reg;
  assign tick         = timer_count_clock & tmr_ctrl[CMW_CTRL_RUN];
  assign at_zero      = tick && (base_timer == CMW_TIMER_ZERO);
  assign clear_on_ch0 = tmr_ctrl[CMW_CTRL_CLR_A] & ~tmr_ctrl[CMW_CTRL_CLR_B];
  assign wr_en        = aw_held & w_held & ~s_axi_bvalid;

  // count clock divider: one-cycle enable every prescale+1 cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      presc_cnt         <= CMW_PRESC_RST;
      timer_count_clock <= 1'b0;
    end
    else if (presc_cnt >= prescale)
    begin
      presc_cnt         <= CMW_PRESC_RST;
      timer_count_clock <= 1'b1;
    end
    else
    begin
      presc_cnt         <= presc_cnt + 16'h0001;
      timer_count_clock <= 1'b0;
    end
  end

  // base timer, up-count only; a channel-0 match arms a clear taken one tick
  // later, so the sequence 0..n+1 spans n+2 counts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      base_timer <= CMW_TIMER_ZERO;
      clr_armed  <= 1'b0;
    end
    else if (tick)
    begin
      if (clr_armed)
      begin
        base_timer <= CMW_TIMER_ZERO;
      end
      else
      begin
        base_timer <= base_timer + 16'h0001;
      end
      clr_armed <= clear_on_ch0 && match_hit[0] && !clr_armed;
    end
    else if (!clear_on_ch0)
    begin
      clr_armed <= 1'b0;
    end
  end

  // per-channel compare reload, waveform state and pin
  for (genvar j = 0; j < NUM_CH; j++)
  begin : g_ch
    logic wave;
    logic was_active;
    cmw_chan_ctrl_t cc;

    assign cc           = channel_output_control[j];
    // matches are judged once per count tick
    assign match_hit[j] = tick && (base_timer == cmp_active[j]);

    // reload: immediately, or at the timer's zero when reload select is set
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        cmp_active[j] <= CMW_CMP_RST;
      end
      else if (!cc.reload_timing_sel || at_zero)
      begin
        cmp_active[j] <= channel_compare_value[j];
      end
    end

    // waveform state; set/reset pairing is not built, that mode holds the default
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        wave       <= 1'b0;
        was_active <= 1'b0;
      end
      else
      begin
        was_active <= active[j];
        if (!active[j] || !was_active)
        begin
          wave <= cc.default_level_sel;
        end
        else
        begin
          case (cc.output_mode_field)
            CMW_MODE_SINGLE:
            begin
              // match wins over zero so a compare value of 0 gives a zero low width
              if (match_hit[j])
              begin
                wave <= 1'b1;
              end
              else if (at_zero)
              begin
                wave <= 1'b0;
              end
            end
            CMW_MODE_PHASE:
            begin
              if (match_hit[j])
              begin
                wave <= ~wave;
              end
            end
            default:
            begin
              wave <= wave;
            end
          endcase
        end
      end
    end

    // pin register: generated level xor level flip, default level xor flip while stopped
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        waveform_out_pin[j] <= 1'b0;
      end
      else
      begin
        waveform_out_pin[j] <= wave ^ cc.level_flip;
      end
    end
  end

  // sticky match flags; a new match wins over the read-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      match_irq_flag <= '0;
    end
    else
    begin
      match_irq_flag <= (match_irq_flag & ~({NUM_CH{rd_stat}})) | (match_hit & active);
    end
  end

  // level interrupt, registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(match_irq_flag & irq_mask);
    end
  end

  // write decode result
  always_comb
  begin
    wr_ok = 1'b1;
    if (aw_addr == CMW_OFF_TMR_CTRL || aw_addr == CMW_OFF_ENABLE)
    begin
      wr_ok = 1'b1;
    end
    else if (aw_addr == CMW_OFF_FUNC_SEL || aw_addr == CMW_OFF_IRQ_MASK)
    begin
      wr_ok = 1'b1;
    end
    else if (aw_addr == CMW_OFF_PRESCALE)
    begin
      wr_ok = 1'b1;
    end
    else if ((aw_addr[7:5] == CMW_PAGE_CH_CTRL || aw_addr[7:5] == CMW_PAGE_CH_CMP)
             && 32'(aw_addr[4:2]) < NUM_CH)
    begin
      wr_ok = 1'b1;
    end
    else
    begin
      wr_ok = 1'b0;  // status and timer are read-only, the rest unmapped
    end
  end

  // register writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tmr_ctrl            <= CMW_CTRL_RST;
      channel_enable_reg  <= '0;
      function_select_reg <= '0;
      irq_mask            <= '0;
      prescale            <= CMW_PRESC_RST;
      for (int k = 0; k < NUM_CH; k++)
      begin
        channel_output_control[k] <= CMW_CHCTRL_RST;
        channel_compare_value[k]  <= CMW_CMP_RST;
      end
    end
    else if (wr_en)
    begin
      if (aw_addr == CMW_OFF_TMR_CTRL)
      begin
        tmr_ctrl <= CMW_CTRL_W'(merge(32'(tmr_ctrl), w_data, w_strb));
      end
      else if (aw_addr == CMW_OFF_ENABLE)
      begin
        channel_enable_reg <= NUM_CH'(merge(32'(channel_enable_reg), w_data, w_strb));
      end
      else if (aw_addr == CMW_OFF_FUNC_SEL)
      begin
        function_select_reg <= NUM_CH'(merge(32'(function_select_reg), w_data, w_strb));
      end
      else if (aw_addr == CMW_OFF_IRQ_MASK)
      begin
        irq_mask <= NUM_CH'(merge(32'(irq_mask), w_data, w_strb));
      end
      else if (aw_addr == CMW_OFF_PRESCALE)
      begin
        prescale <= 16'(merge(32'(prescale), w_data, w_strb));
      end
      else if (aw_addr[7:5] == CMW_PAGE_CH_CTRL && 32'(aw_addr[4:2]) < NUM_CH)
      begin
        channel_output_control[aw_addr[4:2]] <= CMW_CHCTRL_W'(merge(
          32'(channel_output_control[aw_addr[4:2]]), w_data, w_strb));
      end
      else if (aw_addr[7:5] == CMW_PAGE_CH_CMP && 32'(aw_addr[4:2]) < NUM_CH)
      begin
        channel_compare_value[aw_addr[4:2]] <= 16'(merge(
          32'(channel_compare_value[aw_addr[4:2]]), w_data, w_strb));
      end
    end
  end

  // write channels: address and data taken in either order, response after both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CMW_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held       <= 1'b1;
        aw_addr       <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_en)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? CMW_RESP_OKAY : CMW_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read mux
  always_comb
  begin
    rd_mux = '0;
    rd_ok  = 1'b1;
    if (s_axi_araddr[7:2] == CMW_OFF_TMR_CTRL[7:2])
    begin
      rd_mux = 32'(tmr_ctrl);
    end
    else if (s_axi_araddr[7:2] == CMW_OFF_ENABLE[7:2])
    begin
      rd_mux = 32'(channel_enable_reg);
    end
    else if (s_axi_araddr[7:2] == CMW_OFF_FUNC_SEL[7:2])
    begin
      rd_mux = 32'(function_select_reg);
    end
    else if (s_axi_araddr[7:2] == CMW_OFF_IRQ_STAT[7:2])
    begin
      rd_mux = 32'(match_irq_flag);
    end
    else if (s_axi_araddr[7:2] == CMW_OFF_IRQ_MASK[7:2])
    begin
      rd_mux = 32'(irq_mask);
    end
    else if (s_axi_araddr[7:2] == CMW_OFF_TIMER[7:2])
    begin
      rd_mux = 32'(base_timer);
    end
    else if (s_axi_araddr[7:2] == CMW_OFF_PRESCALE[7:2])
    begin
      rd_mux = 32'(prescale);
    end
    else if (s_axi_araddr[7:5] == CMW_PAGE_CH_CTRL && 32'(s_axi_araddr[4:2]) < NUM_CH)
    begin
      rd_mux = 32'(channel_output_control[s_axi_araddr[4:2]]);
    end
    else if (s_axi_araddr[7:5] == CMW_PAGE_CH_CMP && 32'(s_axi_araddr[4:2]) < NUM_CH)
    begin
      rd_mux = 32'(channel_compare_value[s_axi_araddr[4:2]]);
    end
    else
    begin
      rd_ok = 1'b0;
    end
  end

  // reading the status register clears the flags it returned
  assign rd_stat = s_axi_arvalid && s_axi_arready
                   && s_axi_araddr[7:2] == CMW_OFF_IRQ_STAT[7:2];

  // read channel: data one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= CMW_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? CMW_RESP_OKAY : CMW_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: testbench/cmw_top_monitor.sv
// checker: bus handshakes, stopped pins and masked interrupt of the waveform block
`timescale 1ns/1ps
`default_nettype none
module cmw_top_monitor
  import cmw_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int ADDR_W = 8
)(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [NUM_CH-1:0] waveform_out_pin,
  input wire logic              irq
);
  logic [7:0] en_sh;
  logic [7:0] mask_sh;
  logic [2:0] quiet;
  wire        wtake = s_axi_awvalid && s_axi_awready;

  // shadow of enable and mask; the bench offers address and data together
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_sh   <= 8'h00;
      mask_sh <= 8'h00;
    end
    else if (wtake && s_axi_awaddr == CMW_OFF_ENABLE)
      en_sh <= s_axi_wdata[7:0];
    else if (wtake && s_axi_awaddr == CMW_OFF_IRQ_MASK)
      mask_sh <= s_axi_wdata[7:0];
  end

  // cycles since the last write, so pipeline latency after a write is not judged
  always_ff @(posedge aclk)
  begin
    if (!aresetn || wtake)
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both halves land in the holding registers first, the response is raised an edge later
  AST_B_AFTER_WRITE: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_B_HOLDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  AST_R_AFTER_READ: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  AST_READY_LOW_IN_B: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_READY_BACK: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready
    && s_axi_wready) else $error("write ready not restored");
  AST_BAD_READ_SLVERR: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == 8'hFC |=> s_axi_rresp == CMW_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_STOPPED_PIN_STILL: assert property (quiet == 3'h7 |-> ((waveform_out_pin
    ^ $past(waveform_out_pin)) & ~en_sh[NUM_CH-1:0]) == '0)
    else $error("stopped channel pin moved");
  AST_IRQ_MASKED_OFF: assert property (mask_sh == 8'h00 && quiet == 3'h7 |-> !irq)
    else $error("interrupt high while fully masked");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rresp == CMW_RESP_SLVERR);
endmodule
bind cmw_top cmw_top_monitor #(.NUM_CH(NUM_CH), .ADDR_W(ADDR_W)) mon_u (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .waveform_out_pin, .irq);
`default_nettype wire

// file: testbench/cmw_pin_probe.sv
// far-side load: measures high and low widths of each output pin in clock cycles
`timescale 1ns/1ps
`default_nettype none
module cmw_pin_probe (
  input wire logic       aclk,
  input wire logic [7:0] pin
);
  int         hi_w [8] = '{default: 0};
  int         lo_w [8] = '{default: 0};
  int         edges [8] = '{default: 0};
  int         run [8] = '{default: 0};
  logic [7:0] last = 8'h00;

  // a load sees only levels, so widths are counted between observed edges
  always @(posedge aclk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin[i] !== last[i])
      begin
        if (last[i])
          hi_w[i] = run[i];
        else
          lo_w[i] = run[i];
        edges[i]++;
        run[i] = 1;
      end
      else
        run[i]++;
    end
    last = pin;
  end
endmodule
`default_nettype wire

// file: testbench/test_compare_match_waveform_output.sv
// testbench: register-level tests of the compare-match waveform block
`timescale 1ns/1ps
`default_nettype none
module test_compare_match_waveform_output;
  import cmw_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, waveform_out_pin;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          n_mismatch = 0;
  int          checks = 0;
  int          e2;
  // channel setup: ch0 clears the timer at 10, ch3 phase-delayed, ch4 flipped
  logic [39:0] cfg [10] = '{{CMW_OFF_FUNC_SEL, 32'h0}, {8'h60, 32'hA}, {8'h64, 32'h4},
    {8'h68, 32'hC}, {8'h6C, 32'h3}, {8'h4C, 32'h1}, {8'h70, 32'h4}, {8'h50, 32'h20},
    {8'h54, 32'h8}, {8'h58, 32'h28}};

  cmw_top #(.NUM_CH(8), .ADDR_W(8)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .waveform_out_pin, .irq);
  cmw_pin_probe probe_u (.aclk(aclk), .pin(waveform_out_pin));

  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // write: address and data offered together, held until each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    resp = s_axi_rresp;
    rdat = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // whole run is about 66k cycles; this limit only catches a hang
  initial
  begin
    #1000000;
    n_mismatch++;
    report_and_stop;
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    do_reset;
    rd(CMW_OFF_TMR_CTRL);
    check(rdat, 32'h0);
    rd(8'h40);
    check(rdat, 32'h0);
    for (int i = 0; i < 10; i++)
      wr(cfg[i][39:32], cfg[i][31:0]);
    repeat (4) @(posedge aclk);
    check(waveform_out_pin[5], 1'b1);
    check(waveform_out_pin[6], 1'b0);
    e2 = probe_u.edges[2];
    wr(CMW_OFF_ENABLE, 32'h3F);
    wr(CMW_OFF_TMR_CTRL, 32'h3);
    repeat (100) @(posedge aclk);
    check(probe_u.hi_w[1], 32'h8);
    check(probe_u.lo_w[1], 32'h4);
    check(probe_u.hi_w[0], 32'h2);
    check(probe_u.lo_w[0], 32'hA);
    check(probe_u.hi_w[4], 32'h4);
    check(probe_u.lo_w[4], 32'h8);
    check(probe_u.hi_w[3], 32'hC);
    check(probe_u.lo_w[3], 32'hC);
    check(probe_u.edges[2], e2);
    wr(CMW_OFF_IRQ_MASK, 32'h2);
    repeat (4) @(posedge aclk);
    check(irq, 1'b1);
    rd(CMW_OFF_IRQ_STAT);
    check(rdat[2:1], 2'h1);
    wr(CMW_OFF_ENABLE, 32'h0);
    repeat (4) @(posedge aclk);
    rd(CMW_OFF_IRQ_STAT);
    rd(CMW_OFF_IRQ_STAT);
    check(rdat, 32'h0);
    repeat (4) @(posedge aclk);
    check(irq, 1'b0);
    wr(CMW_OFF_IRQ_MASK, 32'h0);
    // refused accesses: read-only timer and an unmapped word
    wr(CMW_OFF_TIMER, 32'h5);
    check(resp, CMW_RESP_SLVERR);
    rd(8'hFC);
    check(resp, CMW_RESP_SLVERR);
    check(rdat, 32'h0);
    // second reset, then one full free-running period of the 16-bit timer
    do_reset;
    wr(8'h64, 32'h4);
    // ch3 phase-delayed on the free-running timer: one whole high phase fits the run
    wr(8'h4C, 32'h1);
    wr(8'h6C, 32'h4);
    wr(CMW_OFF_ENABLE, 32'hA);
    wr(CMW_OFF_TMR_CTRL, 32'h1);
    repeat (65600) @(posedge aclk);
    check(probe_u.hi_w[1], 32'hFFFC);
    check(probe_u.lo_w[1], 32'h4);
    check(probe_u.hi_w[3], 32'h10000);
    report_and_stop;
  end
endmodule
`default_nettype wire
